/* rtl/crossed_pair_muting.sv */
// crossed-pair muting evaluation with optional pre-gate, lamp supervision and sensor test
// assumes sensor and lamp-sense inputs already synchronous to clk, active high
`timescale 1ns/1ps
`include "muting_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module crossed_pair_muting #(
    parameter logic [31:0] CONC_CYCLES  = 32'(64'(`CONC_TIME_MS) * 64'(`CLK_FREQ_MHZ) * 64'd1000),
    parameter logic [31:0] TOTAL_CYCLES = 32'(64'(`TOTAL_TIME_MS) * 64'(`CLK_FREQ_MHZ) * 64'd1000),
    parameter logic [31:0] TEST_PERIOD  = 32'(64'(`TEST_PERIOD_MS) * 64'(`CLK_FREQ_MHZ) * 64'd1000)
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [31:0] regRdata,
    input  wire logic        pair_sensor_first,
    input  wire logic        pair_sensor_second,
    input  wire logic        pre_gate_sensor,
    input  wire logic        curtainClear,
    input  wire logic        lampSense,
    output logic             safetyOut,
    output logic             mutingActive,
    output logic             mutingLamp,
    output logic             mutingLed,
    output logic             sensorTestOut
);
    localparam logic [9:0]  TEST_LAST  = 10'(`TEST_WINDOW_CYC - 1);
    localparam logic [31:0] LAMP_LIMIT = 32'(`LAMP_SETTLE_CYC);

    typedef struct packed {
        muting_pkg::mute_state_t   state;
        logic                      preSeen;
        logic                      curtainBroken;
        logic                      testing;
        logic [9:0]                testCnt;
        muting_pkg::ctrl_t         ctrl;
        logic [31:0]               concLimit;
        logic [31:0]               totalLimit;
        logic [`FAULT_WIDTH-1:0]   faults;
        logic [31:0]               rdata;
    } core_t;

    core_t s;
    core_t next_s;
    logic  bothPair;
    logic  anySensor;
    logic  inhibit;
    logic  [`FAULT_WIDTH-1:0] faultSet;
    logic  [`FAULT_WIDTH-1:0] faultClr;

    timer_if tif[4] ();

    ////////////////////////////////////////////////////////////////////////////
    // timers: 0 concurrence, 1 total time, 2 test period, 3 lamp supervision
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_timer
            mute_timer u_timer (
                .clk   (clk),
                .rst_n (rst_n),
                .tif   (tif[gi])
            );
        end
    endgenerate

    assign tif[0].run   = (s.state == muting_pkg::ST_CYCLE) && s.ctrl.concEn
                          && (pair_sensor_first ^ pair_sensor_second);
    assign tif[0].limit = s.concLimit;
    // the installer sizes this limit for the whole passage
    assign tif[1].run   = (s.state == muting_pkg::ST_MUTE) && s.ctrl.totalEn;
    assign tif[1].limit = s.totalLimit;
    assign tif[2].run   = s.ctrl.testEn && (s.state == muting_pkg::ST_IDLE)
                          && !anySensor && !s.testing;
    assign tif[2].limit = TEST_PERIOD;
    assign tif[3].run   = s.ctrl.lampMon && (s.state == muting_pkg::ST_MUTE)
                          && !lampSense;
    assign tif[3].limit = LAMP_LIMIT;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    assign bothPair  = pair_sensor_first && pair_sensor_second;
    // pre-gate input starts or holds no cycle in plain two-sensor mode
    assign anySensor = pair_sensor_first || pair_sensor_second
                       || (s.ctrl.pregate && pre_gate_sensor);
    // a dead lamp or failed sensor test forbids any new muting start
    assign inhibit   = s.faults[`FAULT_LAMP_BIT] || s.faults[`FAULT_TEST_BIT];

    always_comb
    begin
        next_s   = s;
        faultSet = '0;
        faultClr = '0;
        next_s.rdata = 32'h0000_0000;

        if (regWrite)
        begin
            unique case (regAddr)
                `REG_CTRL:        next_s.ctrl = regWdata[`CTRL_WIDTH-1:0];
                `REG_CONC_LIMIT:  next_s.concLimit = regWdata;
                `REG_TOTAL_LIMIT: next_s.totalLimit = regWdata;
                `REG_FAULT:       faultClr = regWdata[`FAULT_WIDTH-1:0];
                default:          ;
            endcase
        end
        if (regRead)
        begin
            unique case (regAddr)
                `REG_CTRL:        next_s.rdata = {25'h000_0000, s.ctrl};
                `REG_CONC_LIMIT:  next_s.rdata = s.concLimit;
                `REG_TOTAL_LIMIT: next_s.rdata = s.totalLimit;
                `REG_STATUS:      next_s.rdata = {16'h0000, 3'h0, s.faults, 3'h0,
                                                  s.testing, s.preSeen, s.curtainBroken, s.state};
                `REG_FAULT:       next_s.rdata = {27'h000_0000, s.faults};
                default:          next_s.rdata = 32'h0000_0000;
            endcase
        end

        unique case (s.state)
            muting_pkg::ST_IDLE:
            begin
                next_s.curtainBroken = 1'b0;
                if (s.testing)
                begin
                    next_s.testCnt = s.testCnt + 10'h001;
                    if (s.testCnt == TEST_LAST)
                    begin
                        next_s.testing = 1'b0;
                        if (!bothPair)
                            faultSet[`FAULT_TEST_BIT] = 1'b1;
                    end
                end
                else if (anySensor)
                begin
                    next_s.state   = muting_pkg::ST_CYCLE;
                    next_s.preSeen = pre_gate_sensor && !bothPair;
                end
                else if (tif[2].expired)
                begin
                    next_s.testing = 1'b1;
                    next_s.testCnt = 10'h000;
                end
            end
            muting_pkg::ST_CYCLE:
            begin
                if (pre_gate_sensor && !bothPair)
                    next_s.preSeen = 1'b1;
                if (!anySensor)
                    next_s.state = muting_pkg::ST_IDLE;
                else if (tif[0].expired)
                begin
                    next_s.state = muting_pkg::ST_LOCK;
                    faultSet[`FAULT_CONC_BIT] = 1'b1;
                end
                else if (bothPair)
                begin
                    if (inhibit)
                        next_s.state = muting_pkg::ST_LOCK;
                    else if (!s.ctrl.pregate)
                        next_s.state = muting_pkg::ST_MUTE;
                    else if (pre_gate_sensor && s.preSeen)
                        next_s.state = muting_pkg::ST_MUTE;
                    else
                    begin
                        // pair reached first: wrong direction for pre-gate mode
                        next_s.state = muting_pkg::ST_LOCK;
                        faultSet[`FAULT_SEQ_BIT] = 1'b1;
                    end
                end
            end
            muting_pkg::ST_MUTE:
            begin
                if (!curtainClear)
                    next_s.curtainBroken = 1'b1;
                if (!bothPair)
                    next_s.state = muting_pkg::ST_LOCK;
                else if (tif[1].expired)
                begin
                    next_s.state = muting_pkg::ST_LOCK;
                    faultSet[`FAULT_TOTAL_BIT] = 1'b1;
                end
                else if (tif[3].expired)
                begin
                    next_s.state = muting_pkg::ST_LOCK;
                    faultSet[`FAULT_LAMP_BIT] = 1'b1;
                end
                else if (s.ctrl.curtainEnd && s.curtainBroken && curtainClear)
                    next_s.state = muting_pkg::ST_LOCK;
            end
            muting_pkg::ST_LOCK:
            begin
                if (!anySensor)
                    next_s.state = muting_pkg::ST_IDLE;
            end
        endcase

        // hardware set wins over a software clear in the same cycle
        next_s.faults = (s.faults & ~faultClr) | faultSet;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s            <= '0;
            s.state      <= muting_pkg::ST_IDLE;
            s.ctrl       <= `CTRL_RESET;
            s.concLimit  <= CONC_CYCLES;
            s.totalLimit <= TOTAL_CYCLES;
        end
        else
            s <= next_s;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign regRdata      = s.rdata;
    assign mutingActive  = (s.state == muting_pkg::ST_MUTE);
    assign mutingLamp    = mutingActive;
    assign mutingLed     = mutingActive && s.ctrl.led;
    assign sensorTestOut = s.testing;
    // combinational so an interruption outside muting trips in the same cycle
    assign safetyOut     = curtainClear || mutingActive;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    pair_release_a: assert property (mutingActive && !bothPair |=> !mutingActive)
        else $error("muting held after a pair sensor cleared");
    pregate_order_a: assert property (s.ctrl.pregate && $rose(mutingActive)
        |-> $past(pre_gate_sensor) && $past(s.preSeen))
        else $error("pre-gate muting started without leading pre-gate");
    hold_pair_a: assert property (mutingActive && $past(mutingActive)
        |-> $past(bothPair))
        else $error("muting continued without both pair sensors");
    lamp_follow_a: assert property (mutingLamp == mutingActive
        && (!mutingLed || mutingActive))
        else $error("muting indication differs from muting state");
    lamp_fault_a: assert property ($rose(s.faults[`FAULT_LAMP_BIT])
        |-> $past(s.ctrl.lampMon) && !mutingActive)
        else $error("lamp fault without supervision or muting kept");
    test_gate_a: assert property ($rose(sensorTestOut) |-> $past(s.ctrl.testEn)
        ##0 sensorTestOut [*8])
        else $error("sensor test started while disabled or cut short");
    any_dir_a: assert property (!s.ctrl.pregate && s.state == muting_pkg::ST_CYCLE
        && bothPair && !inhibit && !tif[0].expired |=> mutingActive)
        else $error("two-sensor mode refused a valid pair");
    wrong_dir_a: assert property (s.ctrl.pregate && s.state == muting_pkg::ST_CYCLE
        && bothPair && !s.preSeen |=> !mutingActive)
        else $error("pre-gate mode muted in reverse direction");
    // a pair release in the same cycle ends muting first, without the fault
    total_stop_a: assert property (mutingActive && bothPair && tif[1].expired
        |=> !mutingActive ##0 s.faults[`FAULT_TOTAL_BIT])
        else $error("total muting time exceeded without stop");
    cycle_lock_a: assert property (s.state == muting_pkg::ST_LOCK && anySensor
        |=> !mutingActive [*2])
        else $error("muting restarted before the cycle ended");
    trip_now_a: assert property (!curtainClear && !mutingActive |-> !safetyOut)
        else $error("safety output on during unmuted interruption");

    mute_plain_c: cover property (!s.ctrl.pregate && $rose(mutingActive));
    mute_pregate_c: cover property (s.ctrl.pregate && $rose(mutingActive));
    conc_fault_c: cover property ($rose(s.faults[`FAULT_CONC_BIT]));
    curtain_end_c: cover property (mutingActive && s.curtainBroken ##1 !mutingActive);
endmodule : crossed_pair_muting

/* rtl/mute_timer.sv */
// elapsed-time counter: counts while run is high, restarts when run drops
// assumes limit is stable while run is high
`timescale 1ns/1ps
module mute_timer (
    input  wire logic clk,
    input  wire logic rst_n,
    timer_if.tmr      tif
);
    muting_pkg::timer_state_t s;
    muting_pkg::timer_state_t next_s;

    always_comb
    begin
        next_s = s;
        if (!tif.run)
            next_s.count = 32'h0000_0000;
        else if (s.count != 32'hffff_ffff)
            next_s.count = s.count + 32'h0000_0001;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end

    // saturating count, so a stuck run cannot wrap back under the limit
    assign tif.expired = tif.run && (s.count >= tif.limit);
endmodule : mute_timer

/* rtl/muting_pkg.sv */
// types shared by the muting logic and its timers
// assumes muting_regs.svh for field widths
`include "muting_regs.svh"
package muting_pkg;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CYCLE = 2'b01,
        ST_MUTE  = 2'b10,
        ST_LOCK  = 2'b11
    } mute_state_t;

    typedef struct packed {
        logic led;
        logic curtainEnd;
        logic totalEn;
        logic concEn;
        logic testEn;
        logic lampMon;
        logic pregate;
    } ctrl_t;

    typedef struct packed {
        logic [31:0] count;
    } timer_state_t;

endpackage : muting_pkg

/* rtl/muting_regs.svh */
// register offsets, field positions, reset values and timing counts of the muting logic
// assumes a byte-addressed plain register port with 32-bit data
`ifndef MUTING_REGS_SVH
`define MUTING_REGS_SVH

`define CLK_FREQ_MHZ       250

`define REG_CTRL           8'h00
`define REG_CONC_LIMIT     8'h04
`define REG_TOTAL_LIMIT    8'h08
`define REG_STATUS         8'h0c
`define REG_FAULT          8'h10

`define CTRL_PREGATE_BIT   0
`define CTRL_LAMPMON_BIT   1
`define CTRL_TEST_BIT      2
`define CTRL_CONC_BIT      3
`define CTRL_TOTAL_BIT     4
`define CTRL_CURTAIN_BIT   5
`define CTRL_LED_BIT       6
`define CTRL_WIDTH         7
`define CTRL_RESET         7'h02

`define FAULT_CONC_BIT     0
`define FAULT_TOTAL_BIT    1
`define FAULT_LAMP_BIT     2
`define FAULT_TEST_BIT     3
`define FAULT_SEQ_BIT      4
`define FAULT_WIDTH        5

`define CONC_TIME_MS       3000
`define TOTAL_TIME_MS      10000
`define TEST_PERIOD_MS     100
`define TEST_WINDOW_NS     2000
`define LAMP_SETTLE_NS     10000

// least times round up to whole cycles
`define TEST_WINDOW_CYC    ((`TEST_WINDOW_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define LAMP_SETTLE_CYC    ((`LAMP_SETTLE_NS * `CLK_FREQ_MHZ + 999) / 1000)

`endif

/* rtl/timer_if.sv */
// run/limit/expired bundle between the muting core and one of its timers
// assumes a single clock shared by both ends
`timescale 1ns/1ps
interface timer_if;
    logic        run;
    logic [31:0] limit;
    logic        expired;
    modport ctl (output run, output limit, input expired);
    modport tmr (input run, input limit, output expired);
endinterface : timer_if

/* tb/crossed_pair_muting_logic_tb_top.sv */
// self-checking bench of the crossed-pair muting logic
// assumes short timer parameters; lamp settle and test window stay at full length
`timescale 1ns/1ps
`include "muting_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module crossed_pair_muting_logic_tb_top;
    logic        clk          = 1'b0;
    logic        rst_n        = 1'b0;
    logic [7:0]  regAddr      = 8'h00;
    logic [31:0] regWdata     = 32'h0000_0000;
    logic        regWrite     = 1'b0;
    logic        regRead      = 1'b0;
    logic        matFirst     = 1'b0;
    logic        matSecond    = 1'b0;
    logic        matPre       = 1'b0;
    logic        curtainClear = 1'b1;
    logic        lampBroken   = 1'b0;
    logic        testFail     = 1'b0;
    logic        ledOn        = 1'b0;
    logic [31:0] regRdata;
    logic [31:0] rdata;
    logic        pairFirst;
    logic        pairSecond;
    logic        preGate;
    logic        lampSense;
    logic        safetyOut;
    logic        mutingActive;
    logic        mutingLamp;
    logic        mutingLed;
    logic        sensorTestOut;
    int          miscompares  = 0;
    int          comparisons  = 0;

    always #2 clk = ~clk;

    crossed_pair_muting #(
        .CONC_CYCLES (32'h0000_0014),
        .TOTAL_CYCLES(32'h0000_0032),
        .TEST_PERIOD (32'h0000_001e)
    ) i_crossed_pair_muting (
        .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .pair_sensor_first(pairFirst), .pair_sensor_second(pairSecond),
        .pre_gate_sensor(preGate), .curtainClear(curtainClear), .lampSense(lampSense),
        .safetyOut(safetyOut), .mutingActive(mutingActive), .mutingLamp(mutingLamp),
        .mutingLed(mutingLed), .sensorTestOut(sensorTestOut)
    );

    sensor_lamp_model i_sensor_lamp_model (
        .matFirst(matFirst), .matSecond(matSecond), .matPre(matPre),
        .lampBroken(lampBroken), .testFail(testFail), .mutingLamp(mutingLamp),
        .sensorTestOut(sensorTestOut), .sensorFirst(pairFirst),
        .sensorSecond(pairSecond), .sensorPre(preGate), .lampSense(lampSense)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr

    // data stand only in the cycle after the strobe, so sample mid-cycle
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        rdata = regRdata;
    endtask : rd

    task automatic mat(input logic f, input logic s, input logic p);
        @(posedge clk);
        matFirst  <= f;
        matSecond <= s;
        matPre    <= p;
    endtask : mat

    task automatic look(input string w, input logic exp);
        @(negedge clk);
        chk({w, " mute"}, 32'(exp), 32'(mutingActive));
        chk({w, " lamp"}, 32'(exp), 32'(mutingLamp));
        chk({w, " led"}, 32'(exp & ledOn), 32'(mutingLed));
        chk({w, " safety"}, 32'(exp | curtainClear), 32'(safetyOut));
    endtask : look

    task automatic fault_bit(input int b, input logic exp);
        rd(`REG_FAULT);
        chk("fault bit", 32'(exp), 32'(rdata[b]));
        mat(1'b0, 1'b0, 1'b0);
        cyc(3);
        wr(`REG_FAULT, 32'h0000_001f);
    endtask : fault_bit

    ////////////////////////////////////////////////////////////////////////////
    task automatic reg_map;
        rd(`REG_CTRL);
        chk("ctrl reset", 32'h0000_0002, rdata);
        rd(`REG_TOTAL_LIMIT);
        chk("total limit", 32'h0000_0032, rdata);
        wr(`REG_STATUS, 32'h0000_00ff);
        rd(`REG_STATUS);
        chk("status ro", 32'h0000_0000, rdata);
        wr(8'h14, 32'h0000_ffff);
        rd(8'h14);
        chk("unmapped", 32'h0000_0000, rdata);
    endtask : reg_map

    task automatic two_sensor;
        wr(`REG_CTRL, 32'h0000_0062);
        ledOn = 1'b1;
        curtainClear <= 1'b0;
        mat(1'b1, 1'b0, 1'b0);
        cyc(2);
        look("one sensor", 1'b0);
        mat(1'b1, 1'b1, 1'b0);
        cyc(1);
        look("both", 1'b1);
        rd(`REG_STATUS);
        chk("status mute", 32'h0000_0002, rdata & 32'h0000_0003);
        mat(1'b0, 1'b1, 1'b0);
        cyc(1);
        look("one clear", 1'b0);
        mat(1'b1, 1'b1, 1'b0);
        cyc(3);
        look("restart in cycle", 1'b0);
        mat(1'b0, 1'b0, 1'b0);
        cyc(3);
        mat(1'b0, 1'b1, 1'b0);
        cyc(2);
        mat(1'b1, 1'b1, 1'b0);
        cyc(1);
        look("reverse", 1'b1);
        cyc(1);
        // curtain was broken during muting, so clearing it ends muting
        curtainClear <= 1'b1;
        cyc(1);
        look("curtain end", 1'b0);
        mat(1'b0, 1'b0, 1'b0);
        cyc(3);
        ledOn = 1'b0;
    endtask : two_sensor

    task automatic pre_gate;
        wr(`REG_CTRL, 32'h0000_0003);
        mat(1'b0, 1'b0, 1'b1);
        cyc(2);
        mat(1'b1, 1'b1, 1'b1);
        cyc(1);
        look("pre first", 1'b1);
        mat(1'b1, 1'b1, 1'b0);
        cyc(3);
        look("pre dropped", 1'b1);
        mat(1'b0, 1'b0, 1'b0);
        cyc(3);
        mat(1'b1, 1'b1, 1'b0);
        cyc(2);
        mat(1'b1, 1'b1, 1'b1);
        cyc(2);
        look("pre late", 1'b0);
        fault_bit(`FAULT_SEQ_BIT, 1'b1);
    endtask : pre_gate

    task automatic lamp_watch;
        wr(`REG_CTRL, 32'h0000_0002);
        lampBroken <= 1'b1;
        mat(1'b1, 1'b1, 1'b0);
        cyc(2000);
        look("lamp settling", 1'b1);
        cyc(600);
        look("lamp dead", 1'b0);
        fault_bit(`FAULT_LAMP_BIT, 1'b1);
        wr(`REG_CTRL, 32'h0000_0000);
        mat(1'b1, 1'b1, 1'b0);
        cyc(2700);
        look("lamp unwatched", 1'b1);
        mat(1'b0, 1'b0, 1'b0);
        lampBroken <= 1'b0;
        cyc(3);
    endtask : lamp_watch

    task automatic timers;
        wr(`REG_CTRL, 32'h0000_001a);
        mat(1'b1, 1'b0, 1'b0);
        cyc(40);
        mat(1'b1, 1'b1, 1'b0);
        cyc(2);
        look("late second", 1'b0);
        fault_bit(`FAULT_CONC_BIT, 1'b1);
        mat(1'b1, 1'b0, 1'b0);
        cyc(2);
        mat(1'b1, 1'b1, 1'b0);
        cyc(40);
        look("inside total", 1'b1);
        cyc(20);
        look("total over", 1'b0);
        fault_bit(`FAULT_TOTAL_BIT, 1'b1);
    endtask : timers

    task automatic test_wait(input logic lvl, input int lim);
        int n;
        n = 0;
        while (sensorTestOut !== lvl && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        chk("test drive", 32'(lvl), 32'(sensorTestOut));
    endtask : test_wait

    task automatic sensor_test;
        wr(`REG_CTRL, 32'h0000_0006);
        test_wait(1'b1, 100);
        test_wait(1'b0, 600);
        cyc(2);
        rd(`REG_FAULT);
        chk("test good", 32'h0000_0000, 32'(rdata[`FAULT_TEST_BIT]));
        testFail <= 1'b1;
        test_wait(1'b1, 100);
        test_wait(1'b0, 600);
        wr(`REG_CTRL, 32'h0000_0002);
        mat(1'b1, 1'b1, 1'b0);
        cyc(2);
        look("test fault blocks", 1'b0);
        fault_bit(`FAULT_TEST_BIT, 1'b1);
        testFail <= 1'b0;
    endtask : sensor_test

    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    // whole run is under ten thousand cycles
    initial
    begin
        #160000;
        miscompares++;
        final_report();
    end

    initial
    begin
        cyc(8);
        rst_n <= 1'b1;
        reg_map();
        two_sensor();
        pre_gate();
        lamp_watch();
        timers();
        sensor_test();
        final_report();
    end
endmodule : crossed_pair_muting_logic_tb_top

/* tb/sensor_lamp_model.sv */
// muting sensors and external muting lamp at the far side of the muting logic
// assumes the bench commands material position, lamp breakage and test failure
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module sensor_lamp_model (
    input  wire logic matFirst,
    input  wire logic matSecond,
    input  wire logic matPre,
    input  wire logic lampBroken,
    input  wire logic testFail,
    input  wire logic mutingLamp,
    input  wire logic sensorTestOut,
    output logic      sensorFirst,
    output logic      sensorSecond,
    output logic      sensorPre,
    output logic      lampSense
);
    // testable pair sensors answer the test drive unless told to fail
    assign sensorFirst  = matFirst | (sensorTestOut & ~testFail);
    assign sensorSecond = matSecond | (sensorTestOut & ~testFail);
    assign sensorPre    = matPre;
    // a broken lamp draws no current even when driven
    assign lampSense    = mutingLamp & ~lampBroken;
endmodule : sensor_lamp_model
